// ---- hw/dms_pkg.sv ----
// Purpose: shared constants of the dual mode serial slave
// Assumes: single system clock, pins synchronised inside the block
// Notes:   frame positions count rising serial clock edges from one
package dms_pkg;

    // slave address bytes, lsb is the read flag
    localparam logic [7:0] DMS_SLV_WR      = 8'he4;
    localparam logic [7:0] DMS_SLV_RD      = 8'he5;
    localparam int         DMS_BYTE_BITS   = 8;
    localparam int         DMS_ADDR_W      = 8;
    localparam int         DMS_DATA_W      = 8;

    // spi frame layout in rising clock edges
    localparam logic [4:0] DMS_SPI_DEAD    = 5'h02;
    localparam logic [4:0] DMS_SPI_SLV_END = 5'h0a;
    localparam logic [4:0] DMS_SPI_REG_END = 5'h12;
    localparam logic [4:0] DMS_SPI_COMMIT  = 5'h1a;
    localparam logic [4:0] DMS_SPI_LAST    = 5'h1b;

    // i2c bit counter values
    localparam logic [3:0] DMS_I2C_BYTE_DONE = 4'h8;
    localparam logic [3:0] DMS_I2C_LAST_BIT  = 4'h7;

    // system clock
    localparam int         DMS_CLK_PERIOD_NS = 25;
    localparam int         DMS_SYNC_STAGES   = 2;

    // pin indices inside the synchroniser bank
    localparam int         DMS_PIN_CLK     = 0;
    localparam int         DMS_PIN_DATA    = 1;
    localparam int         DMS_PIN_SEL     = 2;
    localparam int         DMS_PIN_CNT     = 3;

    typedef enum logic [2:0] {
        DMS_I_IDLE = 3'b000,
        DMS_I_ADDR = 3'b001,
        DMS_I_ACK  = 3'b010,
        DMS_I_RXB  = 3'b011,
        DMS_I_TXB  = 3'b100,
        DMS_I_RACK = 3'b101
    } dms_i2c_st_t;

endpackage : dms_pkg

// ---- hw/dms_sync.sv ----
// Purpose: two stage synchroniser bank with edge detection
// Assumes: inputs are asynchronous to mclk_in
// Notes:   edges are taken from stage two and a third delay flop
`timescale 1ns/10ps
module dms_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    // raw pins
    input  wire logic [WIDTH-1:0] pin_in,
    // synchronised view
    output logic      [WIDTH-1:0] lvl_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stab_r;
    logic [WIDTH-1:0] dly_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // idle bus lines are high, so reset to high avoids false edges
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    meta_r[g] <= 1'b1;
                    stab_r[g] <= 1'b1;
                    dly_r[g]  <= 1'b1;
                end else begin
                    meta_r[g] <= pin_in[g];
                    stab_r[g] <= meta_r[g];
                    dly_r[g]  <= stab_r[g];
                end
            end
            assign lvl_out[g]  = stab_r[g];
            assign rise_out[g] = stab_r[g] & ~dly_r[g];
            assign fall_out[g] = ~stab_r[g] & dly_r[g];
        end
    endgenerate

endmodule : dms_sync

// ---- hw/dms_shreg.sv ----
// Purpose: msb first byte shift register, loadable
// Assumes: load and shift never asserted together
// Notes:   load wins if both arrive
`timescale 1ns/10ps
module dms_shreg #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    // control
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] load_val_in,
    input  wire logic             shift_in,
    input  wire logic             ser_in,
    // contents
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q_r <= '0;
        end else if (load_in) begin
            q_r <= load_val_in;
        end else if (shift_in) begin
            q_r <= {q_r[WIDTH-2:0], ser_in};
        end
    end

    assign q_out = q_r;

endmodule : dms_shreg

// ---- hw/dms_top.sv ----
// What this block does
// - slave only; master clocks and frames everything
// - answer only slave bytes e4 write, e5 read
// - every byte moves msb first
// - select falling edge puts port in spi mode
// - no acknowledge bit in spi mode
// - spi frame: two dead, three bytes, hold
// - sample data on rising clock in spi
// - commit spi write on 26th rising edge
// - early select rise drops frame, no write
// - change output bit on falling clock in spi
// - first two spi bits are ignored
// - spi read: device drives after register address
// - i2c: hold data low during acknowledge clock
// - i2c read nack: release data, await stop
//
// Purpose: serial control port slave, i2c style or three wire spi style
// Assumes: register file sits outside on the same clock, read data valid one
//          cycle after reg_rd_out; serial clock far slower than mclk_in
// Notes:   sda open drain in i2c mode, push pull during spi read phase
`timescale 1ns/10ps
module dms_top
    import dms_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  sys_rst_in,
    // serial pins
    input  wire logic                  ser_clk_in,
    input  wire logic                  ser_data_in,
    input  wire logic                  ser_data_out_sel_n_in,
    output logic                       ser_data_out,
    output logic                       ser_data_oe_n_out,
    // register file port
    output logic [dms_pkg::DMS_ADDR_W-1:0] reg_addr_out,
    output logic [dms_pkg::DMS_DATA_W-1:0] reg_wdata_out,
    output logic                       reg_wr_out,
    output logic                       reg_rd_out,
    input  wire logic [dms_pkg::DMS_DATA_W-1:0] reg_rdata_in,
    // status
    output logic                       spi_mode_out
);
    import dms_pkg::*;

    logic [DMS_PIN_CNT-1:0] pin_raw;
    logic [DMS_PIN_CNT-1:0] pin_lvl;
    logic [DMS_PIN_CNT-1:0] pin_rise;
    logic [DMS_PIN_CNT-1:0] pin_fall;
    logic                   scl;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   sda;
    logic                   sda_rise;
    logic                   sda_fall;
    logic                   sel_rise;
    logic                   sel_fall;

    logic [7:0]             rx_q;
    logic [7:0]             tx_q;
    logic [7:0]             rx_byte;
    logic                   rx_shift;
    logic                   tx_shift;
    logic                   rd_pend_r;

    // spi engine
    logic                   spi_act_r;
    logic [4:0]             spi_cnt_r;
    logic                   spi_hit_r;
    logic                   spi_rd_r;
    logic                   spi_drv_r;
    logic                   spi_bit_r;
    logic [7:0]             spi_addr_r;
    logic                   spi_wr_req_r;
    logic                   spi_rd_req_r;
    logic [7:0]             spi_wdata_r;
    logic                   spi_rx_shift;
    logic                   spi_tx_shift;

    // i2c engine
    dms_i2c_st_t            i2c_st_r;
    logic [3:0]             i2c_bit_r;
    logic                   i2c_hit_r;
    logic                   i2c_rd_r;
    logic                   i2c_have_reg_r;
    logic                   i2c_ack_r;
    logic [7:0]             i2c_ptr_r;
    logic                   i2c_low_r;
    logic                   i2c_wr_req_r;
    logic                   i2c_rd_req_r;
    logic [7:0]             i2c_wdata_r;
    logic [7:0]             i2c_req_addr_r;
    logic                   i2c_rx_shift;
    logic                   i2c_tx_shift;
    logic                   i2c_ev;

    assign pin_raw[DMS_PIN_CLK]  = ser_clk_in;
    assign pin_raw[DMS_PIN_DATA] = ser_data_in;
    assign pin_raw[DMS_PIN_SEL]  = ser_data_out_sel_n_in;

    dms_sync #(
        .WIDTH      (DMS_PIN_CNT)
    ) u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (pin_raw),
        .lvl_out    (pin_lvl),
        .rise_out   (pin_rise),
        .fall_out   (pin_fall)
    );

    assign scl      = pin_lvl[DMS_PIN_CLK];
    assign scl_rise = pin_rise[DMS_PIN_CLK];
    assign scl_fall = pin_fall[DMS_PIN_CLK];
    assign sda      = pin_lvl[DMS_PIN_DATA];
    assign sda_rise = pin_rise[DMS_PIN_DATA];
    assign sda_fall = pin_fall[DMS_PIN_DATA];
    assign sel_rise = pin_rise[DMS_PIN_SEL];
    assign sel_fall = pin_fall[DMS_PIN_SEL];

    // shared byte shifters, engines never run together
    assign rx_shift = spi_rx_shift | i2c_rx_shift;
    assign tx_shift = spi_tx_shift | i2c_tx_shift;
    assign rx_byte  = {rx_q[6:0], sda};

    dms_shreg #(
        .WIDTH       (DMS_BYTE_BITS)
    ) u_rx (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (1'b0),
        .load_val_in (8'h00),
        .shift_in    (rx_shift),
        .ser_in      (sda),
        .q_out       (rx_q)
    );

    dms_shreg #(
        .WIDTH       (DMS_BYTE_BITS)
    ) u_tx (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (rd_pend_r),
        .load_val_in (reg_rdata_in),
        .shift_in    (tx_shift),
        .ser_in      (1'b0),
        .q_out       (tx_q)
    );

    // spi shift strobes; edges 1 and 2 are dead time
    assign spi_rx_shift = spi_act_r & scl_rise & (spi_cnt_r >= DMS_SPI_DEAD) &
                          (spi_cnt_r < DMS_SPI_COMMIT);
    assign spi_tx_shift = spi_act_r & scl_fall & spi_drv_r &
                          (spi_cnt_r >= DMS_SPI_REG_END) & (spi_cnt_r < DMS_SPI_COMMIT);

    // mode select: falling select enters spi, rising leaves it
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            spi_act_r <= 1'b0;
        end else if (sel_rise) begin
            spi_act_r <= 1'b0;
        end else if (sel_fall) begin
            spi_act_r <= 1'b1;
        end
    end

    // spi frame counter and byte capture
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            spi_cnt_r    <= 5'h00;
            spi_hit_r    <= 1'b0;
            spi_rd_r     <= 1'b0;
            spi_addr_r   <= 8'h00;
            spi_wdata_r  <= 8'h00;
            spi_wr_req_r <= 1'b0;
            spi_rd_req_r <= 1'b0;
        end else begin
            spi_wr_req_r <= 1'b0;
            spi_rd_req_r <= 1'b0;
            if (sel_fall) begin
                spi_cnt_r <= 5'h00;
                spi_hit_r <= 1'b0;
                spi_rd_r  <= 1'b0;
            end else if (spi_act_r && scl_rise && spi_cnt_r < DMS_SPI_LAST) begin
                spi_cnt_r <= spi_cnt_r + 5'h01;
                if (spi_cnt_r == DMS_SPI_SLV_END - 5'h01) begin
                    spi_hit_r <= (rx_byte == DMS_SLV_WR) || (rx_byte == DMS_SLV_RD);
                    spi_rd_r  <= rx_byte[0];
                end
                if (spi_cnt_r == DMS_SPI_REG_END - 5'h01) begin
                    spi_addr_r   <= rx_byte;
                    spi_rd_req_r <= spi_hit_r & spi_rd_r;
                end
                // only a full frame with select still low reaches here
                if (spi_cnt_r == DMS_SPI_COMMIT - 5'h01) begin
                    spi_wdata_r  <= rx_byte;
                    spi_wr_req_r <= spi_hit_r & ~spi_rd_r;
                end
            end
        end
    end

    // spi output: drive from register address end to commit edge
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            spi_drv_r <= 1'b0;
            spi_bit_r <= 1'b1;
        end else if (!spi_act_r || sel_fall) begin
            spi_drv_r <= 1'b0;
            spi_bit_r <= 1'b1;
        end else if (scl_rise && spi_cnt_r == DMS_SPI_REG_END - 5'h01) begin
            spi_drv_r <= spi_hit_r & spi_rd_r;
        end else if (scl_rise && spi_cnt_r == DMS_SPI_COMMIT - 5'h01) begin
            spi_drv_r <= 1'b0;
        end else if (spi_tx_shift) begin
            spi_bit_r <= tx_q[7];
        end
    end

    // i2c strobes
    assign i2c_ev       = ~spi_act_r;
    assign i2c_rx_shift = i2c_ev & scl_rise & (i2c_bit_r < DMS_I2C_BYTE_DONE) &
                          ((i2c_st_r == DMS_I_ADDR) || (i2c_st_r == DMS_I_RXB));
    // ack states still hold the full bit count, so only the byte phase checks it
    assign i2c_tx_shift = i2c_ev & scl_fall &
                          (((i2c_st_r == DMS_I_TXB) && (i2c_bit_r != 4'h0) &&
                            (i2c_bit_r < DMS_I2C_BYTE_DONE)) ||
                           ((i2c_st_r == DMS_I_ACK) && i2c_rd_r) ||
                           ((i2c_st_r == DMS_I_RACK) && i2c_ack_r));

    // i2c engine; start and stop are data edges while clock high
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            i2c_st_r       <= DMS_I_IDLE;
            i2c_bit_r      <= 4'h0;
            i2c_hit_r      <= 1'b0;
            i2c_rd_r       <= 1'b0;
            i2c_have_reg_r <= 1'b0;
            i2c_ack_r      <= 1'b0;
            i2c_ptr_r      <= 8'h00;
            i2c_low_r      <= 1'b0;
            i2c_wr_req_r   <= 1'b0;
            i2c_rd_req_r   <= 1'b0;
            i2c_wdata_r    <= 8'h00;
            i2c_req_addr_r <= 8'h00;
        end else begin
            i2c_wr_req_r <= 1'b0;
            i2c_rd_req_r <= 1'b0;
            if (spi_act_r) begin
                i2c_st_r  <= DMS_I_IDLE;
                i2c_low_r <= 1'b0;
            end else if (scl && sda_fall) begin
                i2c_st_r       <= DMS_I_ADDR;
                i2c_bit_r      <= 4'h0;
                i2c_have_reg_r <= 1'b0;
                i2c_low_r      <= 1'b0;
            end else if (scl && sda_rise) begin
                i2c_st_r  <= DMS_I_IDLE;
                i2c_low_r <= 1'b0;
            end else begin
                unique case (i2c_st_r)
                    DMS_I_IDLE: begin
                        i2c_low_r <= 1'b0;
                    end
                    DMS_I_ADDR, DMS_I_RXB: begin
                        if (scl_rise && i2c_bit_r < DMS_I2C_BYTE_DONE) begin
                            i2c_bit_r <= i2c_bit_r + 4'h1;
                            if (i2c_bit_r == DMS_I2C_LAST_BIT) begin
                                if (i2c_st_r == DMS_I_ADDR) begin
                                    i2c_hit_r <= (rx_byte == DMS_SLV_WR) || (rx_byte == DMS_SLV_RD);
                                    i2c_rd_r  <= rx_byte[0];
                                end else if (!i2c_have_reg_r) begin
                                    i2c_ptr_r      <= rx_byte;
                                    i2c_have_reg_r <= 1'b1;
                                end else begin
                                    i2c_req_addr_r <= i2c_ptr_r;
                                    i2c_wdata_r    <= rx_byte;
                                    i2c_wr_req_r   <= 1'b1;
                                    i2c_ptr_r      <= i2c_ptr_r + 8'h01;
                                end
                            end
                        end else if (scl_fall && i2c_bit_r == DMS_I2C_BYTE_DONE) begin
                            if (i2c_st_r == DMS_I_ADDR && !i2c_hit_r) begin
                                i2c_st_r <= DMS_I_IDLE;
                            end else begin
                                i2c_st_r  <= DMS_I_ACK;
                                i2c_low_r <= 1'b1;
                            end
                        end
                    end
                    DMS_I_ACK: begin
                        if (scl_rise && i2c_rd_r) begin
                            i2c_req_addr_r <= i2c_ptr_r;
                            i2c_rd_req_r   <= 1'b1;
                        end else if (scl_fall) begin
                            i2c_bit_r <= 4'h0;
                            if (i2c_rd_r) begin
                                i2c_st_r  <= DMS_I_TXB;
                                i2c_low_r <= ~tx_q[7];
                            end else begin
                                i2c_st_r  <= DMS_I_RXB;
                                i2c_low_r <= 1'b0;
                            end
                        end
                    end
                    DMS_I_TXB: begin
                        if (scl_rise) begin
                            i2c_bit_r <= i2c_bit_r + 4'h1;
                        end else if (scl_fall) begin
                            if (i2c_bit_r == DMS_I2C_BYTE_DONE) begin
                                i2c_st_r  <= DMS_I_RACK;
                                i2c_low_r <= 1'b0;
                            end else begin
                                i2c_low_r <= ~tx_q[7];
                            end
                        end
                    end
                    DMS_I_RACK: begin
                        if (scl_rise) begin
                            i2c_ack_r <= ~sda;
                            if (!sda) begin
                                i2c_ptr_r      <= i2c_ptr_r + 8'h01;
                                i2c_req_addr_r <= i2c_ptr_r + 8'h01;
                                i2c_rd_req_r   <= 1'b1;
                            end
                        end else if (scl_fall) begin
                            i2c_bit_r <= 4'h0;
                            if (i2c_ack_r) begin
                                i2c_st_r  <= DMS_I_TXB;
                                i2c_low_r <= ~tx_q[7];
                            end else begin
                                i2c_st_r  <= DMS_I_IDLE;
                                i2c_low_r <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        i2c_st_r  <= DMS_I_IDLE;
                        i2c_low_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register port; one request source at a time
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_addr_out  <= 8'h00;
            reg_wdata_out <= 8'h00;
            reg_wr_out    <= 1'b0;
            reg_rd_out    <= 1'b0;
            rd_pend_r     <= 1'b0;
        end else begin
            reg_wr_out <= spi_wr_req_r | i2c_wr_req_r;
            reg_rd_out <= spi_rd_req_r | i2c_rd_req_r;
            rd_pend_r  <= reg_rd_out;
            if (spi_wr_req_r || spi_rd_req_r) begin
                reg_addr_out  <= spi_addr_r;
                reg_wdata_out <= spi_wdata_r;
            end else if (i2c_wr_req_r || i2c_rd_req_r) begin
                reg_addr_out  <= i2c_req_addr_r;
                reg_wdata_out <= i2c_wdata_r;
            end
        end
    end

    // pin driver: spi push pull, i2c open drain, spi never acknowledges
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ser_data_out      <= 1'b1;
            ser_data_oe_n_out <= 1'b1;
            spi_mode_out      <= 1'b0;
        end else begin
            spi_mode_out <= spi_act_r;
            if (spi_act_r) begin
                ser_data_out      <= spi_bit_r;
                ser_data_oe_n_out <= ~spi_drv_r;
            end else begin
                ser_data_out      <= 1'b0;
                ser_data_oe_n_out <= ~i2c_low_r;
            end
        end
    end

endmodule : dms_top

// ---- verif/dms_top_assertions.sv ----
// Purpose: port checks for the serial slave
// Assumes: serial clock far slower than mclk_in
// Notes:   8 cycle bounds cover synchroniser lag
`timescale 1ns/10ps
module dms_top_assertions (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // watched ports
    input wire logic ser_data_out_sel_n_in,
    input wire logic ser_data_out,
    input wire logic ser_data_oe_n_out,
    input wire logic reg_wr_out,
    input wire logic reg_rd_out,
    input wire logic spi_mode_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic rd_seen_r;
    // cleared with the mode so an old read cannot excuse a later drive
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || !spi_mode_out)
            rd_seen_r <= 1'b0;
        else if (reg_rd_out)
            rd_seen_r <= 1'b1;
    end
    sequence spi_read_s;
        spi_mode_out && reg_rd_out;
    endsequence
    sequence spi_drive_s;
        spi_mode_out && $fell(ser_data_oe_n_out);
    endsequence
    mode_enter_a: assert property ($fell(ser_data_out_sel_n_in) |-> ##[2:8] spi_mode_out)
        else $error("spi mode late");
    mode_leave_a: assert property ($rose(ser_data_out_sel_n_in) |-> ##[2:8] !spi_mode_out)
        else $error("spi mode stuck");
    spi_release_a: assert property ($rose(ser_data_out_sel_n_in) |-> ##[2:8] ser_data_oe_n_out)
        else $error("line held after select");
    read_drive_a: assert property (spi_read_s |-> ##[0:4] !ser_data_oe_n_out)
        else $error("read data not driven");
    no_spi_ack_a: assert property (spi_drive_s |-> ##[0:2] (reg_rd_out || rd_seen_r))
        else $error("spi drive without read");
    wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out)
        else $error("write strobe too long");
    wr_in_frame_a: assert property (reg_wr_out && spi_mode_out |-> !ser_data_out_sel_n_in)
        else $error("write after select rise");
    i2c_pull_a: assert property (!spi_mode_out && !ser_data_oe_n_out |-> !ser_data_out)
        else $error("i2c drive not low");
endmodule : dms_top_assertions

bind dms_top dms_top_assertions i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .ser_data_out_sel_n_in(ser_data_out_sel_n_in), .ser_data_out(ser_data_out),
    .ser_data_oe_n_out(ser_data_oe_n_out), .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out),
    .spi_mode_out(spi_mode_out));

// ---- verif/dms_master_model.sv ----
// Purpose: serial bus master for the slave pins
// Assumes: data wire pulled up, resolved outside
// Notes:   spi 200 ns period, i2c 2.5 us period
`timescale 1ns/10ps
module dms_master_model (
    // wire view and pins
    input  wire logic wire_in,
    output logic      clk_out,
    output logic      dat_out,
    output logic      sel_n_out
);
    initial begin
        clk_out = 1'b1; // idle high bus
        dat_out = 1'b1;
        sel_n_out = 1'b1;
    end
    task automatic spi_frame(input logic [7:0] s, a, d, input int n, output logic [7:0] q);
        logic [25:0] b;
        b = {2'b11, s, a, d}; // dead bits high, msb first
        clk_out = 1'b0;
        #50 sel_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            #50 dat_out = (i > 25 || (s[0] && i > 17)) ? 1'b1 : b[25-i];
            #50 clk_out = 1'b1; // one clock per bit
            #90 if (i < 26) q = {q[6:0], wire_in};
            if (i < 26) #10 clk_out = 1'b0; // 27th rise left high
        end
        // select rises before the clock so no extra rise lands in the frame
        #200 sel_n_out = 1'b1;
        dat_out = 1'b1;
        #100 clk_out = 1'b1;
        #1000;
    endtask : spi_frame
    task automatic i2c_bit(input logic b, output logic r);
        #650 dat_out = b;
        #650 clk_out = 1'b1;
        #600 r = wire_in;
        #600 clk_out = 1'b0;
    endtask : i2c_bit
    task automatic i2c_byte(input logic [7:0] b, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], r);
            q[i] = r;
        end
        i2c_bit(1'b1, r); // released, never acks reads
        ack = !r;
    endtask : i2c_byte
    task automatic i2c_start();
        dat_out = 1'b0;
        #600 clk_out = 1'b0;
    endtask : i2c_start
    task automatic i2c_stop();
        #650 dat_out = 1'b0;
        #650 clk_out = 1'b1;
        #600 dat_out = 1'b1;
        #1300;
    endtask : i2c_stop
endmodule : dms_master_model

// ---- verif/test_dual_mode_serial_slave.sv ----
// Purpose: self-checking bench for the serial slave
// Assumes: pulled-up data wire, register file modelled here
// Notes:   serial timing lives in the master model
`timescale 1ns/10ps
module test_dual_mode_serial_slave;
    import dms_pkg::*;
    typedef struct { logic [7:0] s, a, d, q; int n, w; } dms_row_t;
    logic       mclk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       m_clk, m_dat, m_sel_n, dout, oe_n, wr, rd, spi, ack;
    logic [7:0] addr, wdata, last_a, last_d, q;
    logic [7:0] mem [256];
    wire        sda = m_dat & (oe_n | dout);
    int         n_fail = 0, checks_done = 0, wr_cnt = 0, w0;
    dms_row_t   rows [9] = '{'{8'he4, 8'h10, 8'ha5, 8'ha5, 27, 1}, '{8'he4, 8'hff, 8'h00, 8'h00, 27, 1},
        '{8'he5, 8'h10, 8'h00, 8'ha5, 27, 0}, '{8'he6, 8'h11, 8'h3c, 8'h3c, 27, 0},
        '{8'he5, 8'h11, 8'h00, 8'h00, 27, 0}, '{8'he4, 8'h12, 8'h77, 8'h00, 25, 0},
        '{8'he5, 8'h12, 8'h00, 8'h00, 27, 0}, '{8'he4, 8'h12, 8'h77, 8'h77, 26, 1},
        '{8'he7, 8'h12, 8'h00, 8'hff, 27, 0}};
    always #12.5 mclk_in = ~mclk_in;
    dms_top i_dms_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ser_clk_in(m_clk), .ser_data_in(sda),
        .ser_data_out_sel_n_in(m_sel_n), .ser_data_out(dout), .ser_data_oe_n_out(oe_n), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(mem[addr]), .spi_mode_out(spi));
    dms_master_model i_dms_master_model (.wire_in(sda), .clk_out(m_clk), .dat_out(m_dat), .sel_n_out(m_sel_n));
    always @(posedge mclk_in) if (wr) begin
        mem[addr] = wdata;
        last_a = addr;
        last_d = wdata;
        wr_cnt++;
    end
    task automatic check(input logic [7:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic i2c(input logic [7:0] b, input logic a);
        i_dms_master_model.i2c_byte(b, q, ack);
        check({7'h0, ack}, {7'h0, a}, "i2c ack");
    endtask : i2c
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #1000000;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (5) @(posedge mclk_in);
        #2 check({oe_n, dout, wr, rd, spi, 3'h0}, 8'hc0, "reset outputs");
        sys_rst_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        foreach (rows[k]) begin
            w0 = wr_cnt;
            // pins move just after an edge, so synchroniser latency is fixed
            @(posedge mclk_in) #2 i_dms_master_model.spi_frame(rows[k].s, rows[k].a, rows[k].d, rows[k].n, q);
            check(8'(wr_cnt - w0), 8'(rows[k].w), "write count");
            if (rows[k].w > 0) check(last_a, rows[k].a, "write addr");
            if (rows[k].w > 0) check(last_d, rows[k].d, "write data");
            if (rows[k].n > 25) check(q, rows[k].q, "data line");
            $display("spi row %0d done", k);
        end
        // i2c after spi proves the mode went back on select rise
        w0 = wr_cnt;
        @(posedge mclk_in) #2 i_dms_master_model.i2c_start();
        i2c(8'he4, 1'b1);
        i2c(8'h20, 1'b1);
        i2c(8'h3c, 1'b1);
        i2c(8'hc3, 1'b1);
        i_dms_master_model.i2c_stop();
        check(8'(wr_cnt - w0), 8'h02, "i2c writes");
        check(last_a, 8'h21, "i2c pointer");
        $display("i2c write done");
        i_dms_master_model.i2c_start();
        i2c(8'he4, 1'b1);
        i2c(8'h20, 1'b1);
        i_dms_master_model.i2c_stop();
        i_dms_master_model.i2c_start();
        i2c(8'he5, 1'b1);
        i2c(8'hff, 1'b0);
        i_dms_master_model.i2c_stop();
        check(q, 8'h3c, "i2c read");
        i_dms_master_model.i2c_start();
        i2c(8'he6, 1'b0);
        i_dms_master_model.i2c_stop();
        $display("i2c read done");
        tally_and_finish();
    end
endmodule : test_dual_mode_serial_slave
